// >>> design/input_port_with_change_interrupt.sv
`timescale 1ns/10ps
module input_port_with_change_interrupt
  import keyin_pkg::*;
#(
  parameter int WIDTH       = 4,
  parameter bit USE_FILTER  = 1'b1,
  parameter int FILT_TICKS  = FILTER_TICKS
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic             clkEn,
  input  wire logic [WIDTH-1:0] keyInputPins,
  input  wire logic [1:0]       periphDivSelect,
  input  wire logic [7:0]       ioAddr,
  input  wire logic             ioRd,
  input  wire logic             ioWr,
  input  wire logic [3:0]       ioWrData,
  output logic      [3:0]       ioRdData,
  output logic                  irqReq
);
  // register words are four bits
  if (WIDTH != 4) begin : g_bad_width
    $error("input_port_with_change_interrupt: WIDTH must be 4");
  end

  logic [3:0] pinIrqEnableBits_r;
  logic       inputIrqPendingFlag_r;
  logic [3:0] rdData_r;
  logic       irq_r;
  logic       armed_r;
  logic       selLevels;
  logic       selEnable;
  logic       selFlag;
  logic       wrEnable;
  logic       rdFlag;
  logic [3:0] activeBits;
  logic       condRaw;
  logic       condFilt;
  logic       setEvent;
  logic       flag_nxt;
  logic [3:0] rdData_nxt;
  logic [3:0] flagWord;

  tick_if tk ();
  assign tk.divSel = periphDivSelect;

  periph_clk_div u_div (
    .core_clk (core_clk),
    .resetn   (resetn),
    .clkEn    (clkEn),
    .tk       (tk)
  );

  assign selLevels = (ioAddr == PIN_LEVELS_ADDR);
  assign selEnable = (ioAddr == IRQ_ENABLE_ADDR);
  assign selFlag   = (ioAddr == IRQ_FLAG_ADDR);
  assign wrEnable  = ioWr & selEnable;
  assign rdFlag    = ioRd & selFlag;

  // each pin gated by own enable
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_gate
      assign activeBits[i] = keyInputPins[i] & pinIrqEnableBits_r[i];
    end
  endgenerate
  assign condRaw = |activeBits;

  generate
    if (USE_FILTER) begin : g_filt
      key_filter #(.TICKS(FILT_TICKS)) u_filt (
        .core_clk (core_clk),
        .resetn   (resetn),
        .clkEn    (clkEn),
        .tick     (tk.tick),
        .condIn   (condRaw),
        .condOut  (condFilt)
      );
    end else begin : g_nofilt
      assign condFilt = condRaw;
    end
  endgenerate

  // rising of gated condition sets flag
  // re-enable on high pin makes new rise
  assign setEvent = condFilt & ~armed_r;
  // read clears, but a set in same cycle wins
  assign flag_nxt = setEvent | (inputIrqPendingFlag_r & ~rdFlag);

  assign flagWord = 4'(inputIrqPendingFlag_r) << FLAG_BIT;
  assign rdData_nxt = selLevels ? keyInputPins :
                      selEnable ? pinIrqEnableBits_r :
                      selFlag   ? flagWord : 4'h0;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pinIrqEnableBits_r    <= ENABLE_RESET;
      inputIrqPendingFlag_r <= FLAG_RESET;
      armed_r               <= 1'b0;
      rdData_r              <= 4'h0;
      irq_r                 <= 1'b0;
    end else if (clkEn) begin
      if (wrEnable) begin
        pinIrqEnableBits_r <= ioWrData;
      end
      inputIrqPendingFlag_r <= flag_nxt;
      armed_r               <= condFilt;
      if (ioRd) begin
        rdData_r <= rdData_nxt;
      end
      irq_r <= flag_nxt;
    end
  end

  assign ioRdData = rdData_r;
  assign irqReq   = irq_r;
endmodule : input_port_with_change_interrupt

// >>> design/keyin_pkg.sv
// Overview of operation
// - pin data read returns live levels
// - four enable bits, cleared at reset
// - every pin can raise interrupt, maskable
// - unmasked rising level sets shared flag
// - flag at bit two, writes ignored
// - reading flag location clears it
// - reset clears the pending flag
// - re-enabling high pin may set again
// - filter sets flag within 0.5 ms
// - unused flag bits read zero
// - peripheral clock divides by one to four
package keyin_pkg;
  localparam logic [7:0] PIN_LEVELS_ADDR  = 8'h73;
  localparam logic [7:0] IRQ_ENABLE_ADDR  = 8'h75;
  localparam logic [7:0] IRQ_FLAG_ADDR    = 8'h7a;
  localparam int         FLAG_BIT         = 2;
  localparam logic [3:0] ENABLE_RESET     = 4'h0;
  localparam logic       FLAG_RESET       = 1'b0;
  localparam int         FILTER_TIME_US   = 500;
  localparam int         FILTER_REF_KHZ   = 65;
  // longest time rounds down, in peripheral ticks
  localparam int         FILTER_TICKS     = (FILTER_TIME_US * FILTER_REF_KHZ) / 1000;
  localparam logic [1:0] DIV_BY_ONE       = 2'h0;
  localparam logic [1:0] DIV_BY_FOUR      = 2'h3;
endpackage : keyin_pkg

// >>> design/tick_if.sv
`timescale 1ns/10ps
interface tick_if;
  logic       tick;
  logic [1:0] divSel;
  modport src (input divSel, output tick);
  modport dst (output divSel, input tick);
endinterface : tick_if

// >>> design/periph_clk_div.sv
`timescale 1ns/10ps
module periph_clk_div
  import keyin_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic clkEn,
  tick_if.src       tk
);
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic       wrap;
  logic       tick_r;
  assign wrap    = (cnt_r >= tk.divSel);
  assign cnt_nxt = wrap ? 2'h0 : cnt_r + 2'h1;
  assign tk.tick = tick_r;
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cnt_r  <= 2'h0;
      tick_r <= 1'b0;
    end else if (clkEn) begin
      cnt_r  <= cnt_nxt;
      tick_r <= wrap;
    end
  end
endmodule : periph_clk_div

// >>> design/key_filter.sv
`timescale 1ns/10ps
module key_filter
  import keyin_pkg::*;
#(
  parameter int TICKS = FILTER_TICKS
) (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic clkEn,
  input  wire logic tick,
  input  wire logic condIn,
  output logic      condOut
);
  // counter is eight bits wide
  if (TICKS < 1 || TICKS > 255) begin : g_bad_ticks
    $error("key_filter: TICKS out of range");
  end
  logic [7:0] cnt_r;
  logic       out_r;
  logic       stable;
  // half the window, so set lands inside 0.5 ms
  localparam logic [7:0] HALF = 8'((TICKS + 1) / 2);
  assign stable  = (cnt_r >= HALF);
  assign condOut = out_r;
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cnt_r <= 8'h00;
      out_r <= 1'b0;
    end else if (clkEn) begin
      if (condIn == out_r) begin
        cnt_r <= 8'h00;
      end else if (tick) begin
        if (stable) begin
          out_r <= condIn;
          cnt_r <= 8'h00;
        end else begin
          cnt_r <= cnt_r + 8'h01;
        end
      end
    end
  end
endmodule : key_filter

// >>> dv/key_pads.sv
`timescale 1ns/10ps
module key_pads (
  input  wire logic       core_clk,
  input  wire logic [3:0] want,
  output logic      [3:0] keyInputPins
);
  logic [3:0] want_r     = 4'h0;
  logic [3:0] lastWant_r = 4'h0;
  // sampled at the rise, so the bench's falling-edge writes cannot race
  always @(posedge core_clk) begin
    want_r <= want;
  end
  always @(negedge core_clk) begin
    lastWant_r <= want_r;
    keyInputPins <= want_r | (lastWant_r & keyInputPins);
  end
  initial keyInputPins = 4'h0;
endmodule : key_pads

// >>> dv/input_port_with_change_interrupt_asserts.sv
`timescale 1ns/10ps
module ipci_asserts (
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       clkEn,
  input wire logic [3:0] keyInputPins,
  input wire logic [7:0] ioAddr,
  input wire logic       ioRd,
  input wire logic [3:0] ioRdData,
  input wire logic       irqReq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  wire rdF = clkEn && ioRd && ioAddr == 8'h7a;
  wire rdK = clkEn && ioRd && ioAddr == 8'h73;
  wire rdX = clkEn && ioRd && !(ioAddr inside {8'h73, 8'h75, 8'h7a});
  a_read_clears: assert property (rdF && (keyInputPins | $past(keyInputPins)) == 4'h0 |=> !irqReq)
    else $error("flag not cleared");
  a_unused_zero: assert property (rdF |=> ioRdData[3] == 1'b0 && ioRdData[1:0] == 2'h0)
    else $error("unused bits set");
  a_flag_reads: assert property (rdF |=> ioRdData[2] == $past(irqReq))
    else $error("flag bit wrong");
  a_pins_read: assert property (rdK && $stable(keyInputPins) |=> ioRdData == $past(keyInputPins))
    else $error("pin data wrong");
  a_irq_holds: assert property (irqReq && !rdF |=> irqReq)
    else $error("request dropped");
  a_irq_cause: assert property ($rose(irqReq) |-> (keyInputPins | $past(keyInputPins)) != 4'h0)
    else $error("request without pin");
  a_data_holds: assert property (!ioRd |=> $stable(ioRdData))
    else $error("read data moved");
  a_unmapped_zero: assert property (rdX |=> ioRdData == 4'h0)
    else $error("unmapped read nonzero");
endmodule : ipci_asserts
bind input_port_with_change_interrupt ipci_asserts i_chk (.core_clk, .resetn, .clkEn, .keyInputPins,
  .ioAddr, .ioRd, .ioRdData, .irqReq);

// >>> dv/input_port_with_change_interrupt_test.sv
`timescale 1ns/10ps
module input_port_with_change_interrupt_test;
  logic        core_clk = 0, resetn = 0, ioRd = 0, ioWr = 0, pend = 0;
  logic [7:0]  ioAddr = 8'h00;
  logic [3:0]  ioWrData = 4'h0, want = 4'h0, hot, keyInputPins, ioRdData;
  logic        irqReq;
  logic        clkEn = 1;
  logic [1:0]  divSel = 2'h0;
  logic [31:0] seed = 32'h19febaea;
  logic [3:0]  q[$];
  int          nErrors = 0, testsRun = 0;
  always #20 core_clk = ~core_clk;
  key_pads i_pads (.core_clk(core_clk), .want(want), .keyInputPins(keyInputPins));
  input_port_with_change_interrupt #(.USE_FILTER(1'b1), .FILT_TICKS(2)) i_dut (.core_clk(core_clk),
    .resetn(resetn), .clkEn(clkEn), .keyInputPins(keyInputPins), .periphDivSelect(divSel), .ioAddr(ioAddr), .ioRd(ioRd),
    .ioWr(ioWr), .ioWrData(ioWrData), .ioRdData(ioRdData), .irqReq(irqReq));
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic cmp(logic [3:0] g, logic [3:0] e);
    testsRun++;
    if (g !== e) begin
      nErrors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  // reads carry the expected value in d
  task automatic acc(logic w, logic [7:0] a, logic [3:0] d);
    @(negedge core_clk);
    {ioWr, ioRd, ioAddr, ioWrData} = {w, !w, a, d};
    if (!w) q.push_back(d);
    @(negedge core_clk);
    {ioWr, ioRd} = 2'b00;
  endtask : acc
  task automatic conclude();
    if (nErrors == 0 && testsRun > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  always @(posedge core_clk) begin
    if (pend) cmp(ioRdData, q.pop_front());
    pend <= ioRd;
  end
  initial begin
    repeat (3) @(negedge core_clk);
    resetn = 1;
    acc(0, 8'h75, 4'h0);
    acc(1, 8'h7a, 4'hf);
    acc(0, 8'h7a, 4'h0);
    acc(0, 8'h74, 4'h0);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      hot = 4'h1 << i;
      divSel = seed[5:4];
      acc(1, 8'h75, seed[3:0] & ~hot);
      acc(0, 8'h75, seed[3:0] & ~hot);
      want = hot;
      repeat (12) @(negedge core_clk);
      acc(0, 8'h7a, 4'h0);
      acc(1, 8'h75, hot);
      repeat (12) @(negedge core_clk);
      cmp({3'h0, irqReq}, 4'h1);
      acc(0, 8'h73, hot);
      acc(0, 8'h7a, 4'h4);
      acc(0, 8'h7a, 4'h0);
      want = 4'h0;
      repeat (12) @(negedge core_clk);
      want = hot;
      repeat (12) @(negedge core_clk);
      acc(0, 8'h7a, 4'h4);
      want = 4'h0;
      // enables rewritten only once pins are low
      repeat (12) @(negedge core_clk);
    end
    clkEn = 0;
    want = hot;
    repeat (12) @(negedge core_clk);
    cmp({3'h0, irqReq}, 4'h0);
    clkEn = 1;
    repeat (12) @(negedge core_clk);
    cmp({3'h0, irqReq}, 4'h1);
    acc(0, 8'h7a, 4'h4);
    want = 4'h0;
    conclude();
  end
  // about sevenfold the expected run
  initial begin
    #100000;
    nErrors++;
    conclude();
  end
endmodule : input_port_with_change_interrupt_test
